//--- inc/dcsb_pkg.sv
package dcsb_pkg;

   // ======================================================================
   // control/status register layout (8 bits)
   // ======================================================================
   localparam int DCSB_PERMIT_BIT = 7;   // background_permit
   localparam int DCSB_ACTIVE_BIT = 6;   // background_mode_active
   localparam int DCSB_BKEN_BIT = 5;     // breakpoint_enable
   localparam int DCSB_FTS_BIT = 4;      // force_tag_select
   localparam int DCSB_CLKSEL_BIT = 3;   // comm_clock_select
   localparam int DCSB_WS_BIT = 2;       // wait_stop_status
   localparam int DCSB_WSF_BIT = 1;      // wait_stop_failure
   localparam int DCSB_DVF_BIT = 0;      // data_valid_failure

   // writable control bits of the status/control byte
   localparam logic [7:0] DCSB_CTRL_MASK = 8'h_b8;

   // ======================================================================
   // reset values
   // ======================================================================
   localparam logic [7:0] DCSB_CTRL_RESET = 8'h_00;
   localparam logic [15:0] DCSB_BKPT_RESET = 16'h_0000;

   // ======================================================================
   // debug command codes on the command port
   // ======================================================================
   typedef enum logic [2:0] {
      DCSB_CMD_NONE,
      DCSB_CMD_READ_STATUS,
      DCSB_CMD_WRITE_CONTROL,
      DCSB_CMD_BREAKPOINT_READ_CMD,
      DCSB_CMD_BREAKPOINT_WRITE_CMD,
      DCSB_CMD_BACKGROUND
   } dcsb_cmd_t;

   // command request carried as one bundle
   typedef struct packed {
      logic valid;        // one-cycle command strobe
      dcsb_cmd_t code;    // which debug command
      logic [15:0] wdata; // write data, byte commands use [7:0]
   } dcsb_req_t;

   // processor-side status bundle
   typedef struct packed {
      logic in_wait_stop;   // cpu sits in wait or stop
      logic mem_fail_ws;    // memory command lost to wait/stop
      logic insn_boundary;  // instruction boundary this cycle
      logic fetch_valid;    // opcode fetch this cycle
      logic queue_end;      // queue head opcode about to execute
      logic queue_end_tag;  // tag riding with the queue head
      logic exit_bg;        // go/return from background this cycle
      logic bg_insn;        // background opcode executed
   } dcsb_cpu_t;

endpackage

//--- rtl/dcsb_bkpt_cmp.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// address comparator of the breakpoint
// ==========================================================================
module dcsb_bkpt_cmp (
   input wire logic [15:0] addr,
   input wire logic [15:0] match,
   input wire logic enable,
   input wire logic force_sel,
   output logic force_hit,
   output logic tag_hit
);
   import dcsb_pkg::*;

   logic same; // address equals match value

   // compare only matters while enabled
   always_comb begin
      same = (addr == match);
      force_hit = enable & force_sel & same;
      tag_hit = enable & ~force_sel & same;
   end

endmodule // dcsb_bkpt_cmp

`default_nettype wire

//--- rtl/dcsb_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Overview of operation
// - 8-bit control/status byte, commands only
// - 16-bit breakpoint match register
// - permit bit frozen during background mode
// - four status bits read-only
// - clock select writable at any time
// - permit gates entry to background mode
// - permit cleared by a control write outside background mode
// - active bit shows background mode
// - breakpoint disabled requests nothing
// - force mode: match stops at boundary
// - tag mode: tagged opcode enters background
// - clock select resets to alternate source
// - wait/stop status incl. background from it
// - background command leaves wait/stop
// - memory command lost to wait/stop flagged
// - data-valid failure never set here
// - dedicated commands reach both registers
// - breakpoint enable resets to zero
// ==========================================================================
module dcsb_ctrl (
   input wire logic clk,
   input wire logic reset,
   input wire dcsb_pkg::dcsb_req_t req,
   output logic [15:0] rdata,
   output logic rvalid,
   output logic bg_refused,
   input wire dcsb_pkg::dcsb_cpu_t cpu,
   input wire logic [15:0] cpu_addr,
   output logic bg_request,
   output logic bg_mode_active,
   output logic comm_clock_select,
   output logic tag_opcode
);
   import dcsb_pkg::*;

   // =======================================================================
   // state
   // =======================================================================
   logic [7:0] ctrl_r;    // writable control bits only
   logic [7:0] ctrl_nxt;
   logic [15:0] bkpt_r;   // breakpoint match address
   logic [15:0] bkpt_nxt;
   logic active_r;        // background mode active
   logic active_nxt;
   logic wsf_r;           // wait/stop failure sticky
   logic wsf_nxt;
   logic [15:0] rdata_r;  // read answer
   logic [15:0] rdata_nxt;
   logic rvalid_r;        // read answer strobe
   logic rvalid_nxt;
   logic refused_r;       // background entry refused
   logic refused_nxt;

   // =======================================================================
   // helpers
   // =======================================================================
   logic ws_status;       // wait/stop status bit
   logic force_hit;       // force breakpoint match
   logic tag_hit;         // tag breakpoint match
   logic enter_bg;        // any cause asks for background
   logic bg_cmd;          // background command strobe
   logic [7:0] status_byte; // assembled read-status value

   // merge one control write into the writable bits
   function automatic logic [7:0] merge_ctrl(input logic [7:0] old,
                                             input logic [7:0] wr,
                                             input logic frozen);
      logic [7:0] mask;
      mask = DCSB_CTRL_MASK;
      if (frozen) begin
         mask[DCSB_PERMIT_BIT] = 1'b0;
      end
      merge_ctrl = (old & ~mask) | (wr & mask);
   endfunction

   // =======================================================================
   // sub blocks
   // =======================================================================
   dcsb_bkpt_cmp u_cmp (
      .addr(cpu_addr),
      .match(bkpt_r),
      .enable(ctrl_r[DCSB_BKEN_BIT]),
      .force_sel(ctrl_r[DCSB_FTS_BIT]),
      .force_hit(force_hit),
      .tag_hit(tag_hit)
   );

   dcsb_ws_track u_ws (
      .clk(clk),
      .reset(reset),
      .in_wait_stop(cpu.in_wait_stop),
      .bg_from_ws(bg_cmd & cpu.in_wait_stop & ctrl_r[DCSB_PERMIT_BIT]),
      .bg_active(active_r),
      .ws_status(ws_status)
   );

   // =======================================================================
   // combinational next state
   // =======================================================================
   always_comb begin
      bg_cmd = req.valid && (req.code == DCSB_CMD_BACKGROUND);
      // force match taken at boundary, tagged opcode at queue end
      enter_bg = bg_cmd
         | (force_hit & cpu.insn_boundary)
         | (cpu.queue_end & cpu.queue_end_tag)
         | cpu.bg_insn;
      status_byte = ctrl_r;
      status_byte[DCSB_ACTIVE_BIT] = active_r;
      status_byte[DCSB_WS_BIT] = ws_status;
      status_byte[DCSB_WSF_BIT] = wsf_r;
      status_byte[DCSB_DVF_BIT] = 1'b0; // no slow memory

      ctrl_nxt = ctrl_r;
      bkpt_nxt = bkpt_r;
      active_nxt = active_r;
      wsf_nxt = wsf_r;
      rdata_nxt = rdata_r;
      rvalid_nxt = 1'b0;
      refused_nxt = 1'b0;

      // register commands
      if (req.valid) begin
         case (req.code)
            DCSB_CMD_READ_STATUS: begin
               rdata_nxt = {8'h_00, status_byte};
               rvalid_nxt = 1'b1;
            end
            DCSB_CMD_WRITE_CONTROL: begin
               ctrl_nxt = merge_ctrl(ctrl_r, req.wdata[7:0], active_r);
            end
            DCSB_CMD_BREAKPOINT_READ_CMD: begin
               rdata_nxt = bkpt_r;
               rvalid_nxt = 1'b1;
            end
            DCSB_CMD_BREAKPOINT_WRITE_CMD: begin
               bkpt_nxt = req.wdata;
            end
            default: begin
               // background and idle handled below
            end
         endcase
      end

      // background entry needs the permit bit
      if (cpu.exit_bg) begin
         active_nxt = 1'b0;
      end
      if (enter_bg && !active_r) begin
         if (ctrl_r[DCSB_PERMIT_BIT]) begin
            active_nxt = 1'b1;
         end else begin
            refused_nxt = 1'b1;
         end
      end

      // failure flag is sticky; any later control write leaves it
      if (cpu.mem_fail_ws) begin
         wsf_nxt = 1'b1;
      end else if (bg_cmd && active_nxt) begin
         wsf_nxt = 1'b0; // cleared once recovery starts
      end
   end

   // =======================================================================
   // registers
   // =======================================================================
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_r <= DCSB_CTRL_RESET;
         bkpt_r <= DCSB_BKPT_RESET;
         active_r <= 1'b0;
         wsf_r <= 1'b0;
         rdata_r <= 16'h_0000;
         rvalid_r <= 1'b0;
         refused_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         bkpt_r <= bkpt_nxt;
         active_r <= active_nxt;
         wsf_r <= wsf_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         refused_r <= refused_nxt;
      end
   end

   // =======================================================================
   // outputs
   // =======================================================================
   // request only while permitted and not already active
   assign bg_request = active_nxt & ~active_r;
   assign bg_mode_active = active_r;
   assign comm_clock_select = ctrl_r[DCSB_CLKSEL_BIT];
   assign tag_opcode = tag_hit & cpu.fetch_valid;
   assign rdata = rdata_r;
   assign rvalid = rvalid_r;
   assign bg_refused = refused_r;

endmodule // dcsb_ctrl

`default_nettype wire

//--- rtl/dcsb_ws_track.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// wait/stop status tracker
// ==========================================================================
module dcsb_ws_track (
   input wire logic clk,
   input wire logic reset,
   input wire logic in_wait_stop,
   input wire logic bg_from_ws,
   input wire logic bg_active,
   output logic ws_status
);
   import dcsb_pkg::*;

   logic carry_r;   // background entered from wait/stop
   logic carry_nxt; // next value

   // carry holds while background lasts, dropped when it ends
   always_comb begin
      carry_nxt = carry_r;
      if (bg_from_ws) begin
         carry_nxt = 1'b1;
      end else if (!bg_active) begin
         carry_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         carry_r <= 1'b0;
      end else begin
         carry_r <= carry_nxt;
      end
   end

   assign ws_status = in_wait_stop | carry_r;

endmodule // dcsb_ws_track

`default_nettype wire

//--- tb/dcsb_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ======
// port checks of the debug control block
// ======
module dcsb_ctrl_assertions
   import dcsb_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire dcsb_pkg::dcsb_req_t req,
   input wire logic [15:0] rdata,
   input wire logic rvalid,
   input wire logic bg_refused,
   input wire dcsb_pkg::dcsb_cpu_t cpu,
   input wire logic [15:0] cpu_addr,
   input wire logic bg_request,
   input wire logic bg_mode_active,
   input wire logic comm_clock_select,
   input wire logic tag_opcode
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // status answer cycle
   sequence s_rs_ans;
      rvalid && $past(req.code) == DCSB_CMD_READ_STATUS;
   endsequence
   // control write with no entry or exit racing it
   sequence s_wr_quiet;
      req.valid && req.code == DCSB_CMD_WRITE_CONTROL && !bg_request
         && !cpu.exit_bg;
   endsequence
   a_read_answer: assert property (req.valid && req.code ==
      DCSB_CMD_READ_STATUS |=> rvalid) else $error("no status answer");
   a_status_pad: assert property (s_rs_ans |-> rdata[15:8] == 8'h_00
      && !rdata[0]) else $error("status pad or dvf set");
   a_clksel_read: assert property (s_rs_ans |-> rdata[3] ==
      comm_clock_select) else $error("clock select mismatch");
   // ws registered or not: wait two edges before judging it
   a_ws_read: assert property (s_rs_ans ##0 $past(cpu.in_wait_stop)
      && $past(cpu.in_wait_stop, 2) |-> rdata[2]) else $error("ws lost");
   a_entry_next: assert property (bg_request |=> bg_mode_active)
      else $error("entry not taken");
   a_entry_cause: assert property ($rose(bg_mode_active) |->
      $past(bg_request)) else $error("active without request");
   a_refused_idle: assert property (bg_refused |-> !bg_mode_active)
      else $error("refused but active");
   a_active_holds: assert property (bg_mode_active && !cpu.exit_bg |=>
      bg_mode_active) else $error("active dropped");
   a_ro_active: assert property (s_wr_quiet |=> $stable(bg_mode_active))
      else $error("write moved active bit");
   a_tag_fetch: assert property (tag_opcode |-> cpu.fetch_valid)
      else $error("tag without fetch");
endmodule // dcsb_ctrl_assertions
`default_nettype wire

//--- tb/dcsb_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ======
// debug host: issues one serial command at a time
// ======
module dcsb_host_model
   import dcsb_pkg::*;
(
   input wire logic clk,
   output var dcsb_pkg::dcsb_req_t req,
   input wire logic [15:0] rdata,
   input wire logic rvalid
);
   initial req = '0;
   // strobe one cycle, answer taken a cycle later; unknown if none came
   task automatic xfer(input dcsb_cmd_t c, input logic [15:0] w,
      output logic [15:0] r);
      @(negedge clk);
      req = '{valid: 1'b1, code: c, wdata: w};
      @(negedge clk);
      req.valid = 1'b0;
      r = rvalid ? rdata : 'x;
   endtask
endmodule // dcsb_host_model
`default_nettype wire

//--- tb/tb_dcsb_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
   $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_dcsb_ctrl;
   import dcsb_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   dcsb_req_t req;
   dcsb_cpu_t cpu = '0; // processor side, driven here
   logic [15:0] cpu_addr = 16'h_0000;
   logic [15:0] rdata;
   logic rvalid, bg_refused, bg_request, bg_mode_active;
   logic comm_clock_select, tag_opcode;
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   always #25 clk = ~clk;
   dcsb_ctrl DUT (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
      .rvalid(rvalid), .bg_refused(bg_refused), .cpu(cpu),
      .cpu_addr(cpu_addr), .bg_request(bg_request),
      .bg_mode_active(bg_mode_active),
      .comm_clock_select(comm_clock_select), .tag_opcode(tag_opcode));
   dcsb_host_model u_host (.clk(clk), .req(req), .rdata(rdata),
      .rvalid(rvalid));
   task stop_test;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one command; reads compared with e
   task automatic cmd(input dcsb_cmd_t c, input logic [15:0] w,
      input logic [15:0] e);
      logic [15:0] r;
      u_host.xfer(c, w, r);
      if (c == DCSB_CMD_READ_STATUS || c == DCSB_CMD_BREAKPOINT_READ_CMD) `CHK(r, e)
   endtask
   task step;
      @(negedge clk);
   endtask
   // run is well under 100 cycles; a hang is cut here
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         fails++;
         stop_test;
      end
   end
   initial begin
      repeat (12) @(negedge clk);
      reset = 1'b0;
      cmd(DCSB_CMD_READ_STATUS, 16'h_0000, 16'h_0000);
      cmd(DCSB_CMD_BREAKPOINT_READ_CMD, 16'h_0000, 16'h_0000);
      `CHK(comm_clock_select, 1'b0)
      cmd(DCSB_CMD_BACKGROUND, 16'h_0000, 16'h_0000);
      `CHK({bg_refused, bg_mode_active}, 2'b10)
      $display("test reset_refuse done");
      cmd(DCSB_CMD_BREAKPOINT_WRITE_CMD, 16'h_1234, 16'h_0000);
      cmd(DCSB_CMD_BREAKPOINT_READ_CMD, 16'h_0000, 16'h_1234);
      cmd(DCSB_CMD_WRITE_CONTROL, 16'h_ffff, 16'h_0000);
      cmd(DCSB_CMD_READ_STATUS, 16'h_0000, 16'h_00b8);
      `CHK(comm_clock_select, 1'b1)
      // host arms the breakpoint before letting code run
      cmd(DCSB_CMD_WRITE_CONTROL, 16'h_00b0, 16'h_0000);
      cpu_addr = 16'h_1234;
      cpu.insn_boundary = 1'b1;
      #1 `CHK(bg_request, 1'b1)
      step();
      cpu.insn_boundary = 1'b0;
      cmd(DCSB_CMD_READ_STATUS, 16'h_0000, 16'h_00f0);
      cmd(DCSB_CMD_WRITE_CONTROL, 16'h_0008, 16'h_0000);
      cmd(DCSB_CMD_READ_STATUS, 16'h_0000, 16'h_00c8);
      cpu.exit_bg = 1'b1;
      step();
      cpu.exit_bg = 1'b0;
      `CHK(bg_mode_active, 1'b0)
      $display("test force done");
      // breakpoint off: match and boundary must do nothing
      cmd(DCSB_CMD_WRITE_CONTROL, 16'h_0090, 16'h_0000);
      cpu = '{insn_boundary: 1'b1, fetch_valid: 1'b1, default: 1'b0};
      #1 `CHK({bg_request, tag_opcode}, 2'b00)
      step();
      cpu = '0;
      cmd(DCSB_CMD_WRITE_CONTROL, 16'h_00a0, 16'h_0000);
      cpu.fetch_valid = 1'b1;
      #1 `CHK(tag_opcode, 1'b1)
      step();
      cpu = '{queue_end: 1'b1, queue_end_tag: 1'b1, default: 1'b0};
      step();
      cpu = '0;
      `CHK(bg_mode_active, 1'b1)
      cpu.exit_bg = 1'b1;
      step();
      cpu.exit_bg = 1'b0;
      $display("test tag done");
      cpu.in_wait_stop = 1'b1;
      cmd(DCSB_CMD_READ_STATUS, 16'h_0000, 16'h_00a4);
      cpu.mem_fail_ws = 1'b1;
      step();
      cpu.mem_fail_ws = 1'b0;
      cmd(DCSB_CMD_READ_STATUS, 16'h_0000, 16'h_00a6);
      // recovery: background first, then control write and status read
      cmd(DCSB_CMD_BACKGROUND, 16'h_0000, 16'h_0000);
      cpu.in_wait_stop = 1'b0;
      `CHK(bg_mode_active, 1'b1)
      cmd(DCSB_CMD_WRITE_CONTROL, 16'h_0007, 16'h_0000);
      cmd(DCSB_CMD_READ_STATUS, 16'h_0000, 16'h_00c4);
      $display("test wait_stop done");
      // background opcode is one more entry cause behind the permit bit
      cpu.exit_bg = 1'b1;
      step();
      cpu.exit_bg = 1'b0;
      `CHK(bg_mode_active, 1'b0)
      cpu.bg_insn = 1'b1;
      #1 `CHK(bg_request, 1'b1)
      step();
      cpu.bg_insn = 1'b0;
      `CHK(bg_mode_active, 1'b1)
      $display("test bg_opcode done");
      stop_test;
   end
endmodule // tb_dcsb_ctrl
bind dcsb_ctrl dcsb_ctrl_assertions u_chk (.clk(clk), .reset(reset),
   .req(req), .rdata(rdata), .rvalid(rvalid), .bg_refused(bg_refused),
   .cpu(cpu), .cpu_addr(cpu_addr), .bg_request(bg_request),
   .bg_mode_active(bg_mode_active),
   .comm_clock_select(comm_clock_select), .tag_opcode(tag_opcode));
`default_nettype wire
